// File: bench/hpa_regfile.sv
`timescale 1ns/10ps
// General register file standing on the far side of the unit
module hpa_regfile (
  input wire logic clk_in,
  input wire logic [4:0] rd1_idx_in,
  input wire logic [4:0] rd2_idx_in,
  input wire logic wr_en_in,
  input wire logic [4:0] wr_idx_in,
  input wire logic [31:0] wr_data_in,
  output logic [31:0] rd1_out,
  output logic [31:0] rd2_out
);
  logic [31:0] gr [32];
  assign rd1_out = gr[rd1_idx_in];
  assign rd2_out = gr[rd2_idx_in];
  // Write back of both lane results
  always @(posedge clk_in)
  begin
    if (wr_en_in)
    begin
      gr[wr_idx_in] <= wr_data_in;
    end
  end
endmodule

// File: bench/tb_halfword_parallel_arith.sv
`timescale 1ns/10ps
module tb_halfword_parallel_arith;
  logic clk_in, reset_in, issue_in, wr_en;
  logic [31:0] instr_in, src1, src2, result;
  logic [4:0] idx1, idx2, wr_idx;
  int mismatches, samples_checked, cycles;
  hpa_halfword_parallel_arith DUT (.clk_in(clk_in), .reset_in(reset_in), .issue_in(issue_in),
    .instr_in(instr_in), .src1_in(src1), .src2_in(src2), .src1_idx_out(idx1), .src2_idx_out(idx2),
    .wr_en_out(wr_en), .wr_idx_out(wr_idx), .result_out(result));
  hpa_regfile m (.clk_in(clk_in), .rd1_idx_in(idx1), .rd2_idx_in(idx2), .wr_en_in(wr_en),
    .wr_idx_in(wr_idx), .wr_data_in(result), .rd1_out(src1), .rd2_out(src2));
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  function automatic logic [15:0] lane(input logic [15:0] a, b, input logic [1:0] op, sat);
    logic signed [17:0] x, s;
    x = (sat == 2'h0) ? {2'h0, a} : {{2{a[15]}}, a};
    s = (op == 2'h1) ? x - {{2{b[15]}}, b} : x + {{2{b[15]}}, b};
    if (op == 2'h2)
    begin
      s = {2'h0, a} + {2'h0, b};
      return {s[16], s[15:2], s[1] | s[0]};
    end
    if (sat == 2'h1)
      return (s > 32767) ? 16'h7FFF : (s < -32768) ? 16'h8000 : s[15:0];
    if (sat == 2'h0)
      return (s > 65535) ? 16'hFFFF : (s < 0) ? 16'h0000 : s[15:0];
    return s[15:0];
  endfunction
  function automatic logic [31:0] word(input logic [1:0] op, sat, input logic [4:0] t);
    if (op == 2'h2)
      return {6'h02, 5'h02, 5'h01, 4'h0, 6'h0B, 1'b0, t};
    return {6'h02, 5'h02, 5'h01, 4'h0, (op == 2'h1) ? 4'h1 : 4'h3, sat, 1'b0, t};
  endfunction
  task automatic check(input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // One issue and its write-back, entered just after an edge
  task automatic run(input logic [1:0] op, sat, input logic [31:0] a, b, input logic [4:0] t);
    logic [31:0] exp;
    exp = {lane(a[31:16], b[31:16], op, sat), lane(a[15:0], b[15:0], op, sat)};
    m.gr[1] = a;
    m.gr[2] = b;
    instr_in = word(op, sat, t);
    issue_in = 1'b1;
    #1;
    check({22'h0, idx2, idx1}, {22'h0, 5'h02, 5'h01});
    @(posedge clk_in);
    #1;
    issue_in = 1'b0;
    check({31'h0, wr_en}, 32'h1);
    check({27'h0, wr_idx}, {27'h0, t});
    check(result, exp);
    @(posedge clk_in);
    #1;
    check({31'h0, wr_en}, 32'h0);
    check(m.gr[t], exp);
  endtask
  task automatic t_sum_modes;
    logic [1:0] sats [4] = '{2'h3, 2'h1, 2'h0, 2'h2};
    foreach (sats[i])
    begin
      run(2'h0, sats[i], 32'h7FFF_FFFF, 32'h0001_0001, 5'h03);
      run(2'h0, sats[i], 32'h8000_0001, 32'h8000_FFFE, 5'h04);
      run(2'h0, sats[i], 32'hFFFF_7FFF, 32'h0001_0001, 5'h0A);
    end
  endtask
  task automatic t_diff_modes;
    logic [1:0] sats [3] = '{2'h3, 2'h1, 2'h0};
    foreach (sats[i])
    begin
      run(2'h1, sats[i], 32'h8000_0001, 32'h0001_0002, 5'h05);
      run(2'h1, sats[i], 32'h7FFF_FFFF, 32'hFFFF_8000, 5'h06);
    end
  endtask
  task automatic t_average;
    run(2'h2, 2'h0, 32'hFFFF_0001, 32'hFFFF_0002, 5'h07);
    run(2'h2, 2'h0, 32'h0002_8000, 32'h0000_8000, 5'h1F);
  endtask
  task automatic t_refused;
    logic [31:0] prev;
    prev = result;
    instr_in = word(2'h0, 2'h0, 5'h08);
    instr_in[11:8] = 4'h2;
    issue_in = 1'b1;
    @(posedge clk_in);
    #1;
    check({31'h0, wr_en}, 32'h0);
    instr_in = word(2'h2, 2'h0, 5'h08);
    instr_in[5] = 1'b1;
    @(posedge clk_in);
    #1;
    issue_in = 1'b0;
    check({31'h0, wr_en}, 32'h0);
    @(posedge clk_in);
    #1;
    check(result, prev);
  endtask
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      test_done();
    end
  end
  initial
  begin
    reset_in = 1'b1;
    issue_in = 1'b0;
    instr_in = 32'h0000_0000;
    repeat (5) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    check({26'h0, wr_en, wr_idx}, 32'h0);
    check(result, 32'h0);
    t_sum_modes();
    t_diff_modes();
    t_average();
    t_refused();
    test_done();
  end
endmodule

// File: rtl/hpa_defs.svh
`ifndef HPA_DEFS_SVH
`define HPA_DEFS_SVH

// Instruction word fields, bit 31 is the word's leftmost bit
`define HPA_OPC_MSB 31
`define HPA_OPC_LSB 26
`define HPA_SRC2_MSB 25
`define HPA_SRC2_LSB 21
`define HPA_SRC1_MSB 20
`define HPA_SRC1_LSB 16
`define HPA_ZERO3_MSB 15
`define HPA_ZERO3_LSB 13
`define HPA_ZERO1_BIT 12
`define HPA_SUB_MSB 11
`define HPA_SUB_LSB 8
`define HPA_SUB6_LSB 6
`define HPA_SAT_MSB 7
`define HPA_SAT_LSB 6
`define HPA_TAIL_BIT 5
`define HPA_TGT_MSB 4
`define HPA_TGT_LSB 0

// Codes
`define HPA_MAJOR_OPC 6'h02
`define HPA_SUB_SUM 4'h3
`define HPA_SUB_DIFF 4'h1
`define HPA_SUB_AVG 6'h0B

// Clamp values
`define HPA_SMAX 16'h7FFF
`define HPA_SMIN 16'h8000
`define HPA_UMAX 16'hFFFF
`define HPA_UMIN 16'h0000

// Reset values
`define HPA_RESULT_RST 32'h0000_0000
`define HPA_TGT_RST 5'h00

`endif

// File: rtl/hpa_pkg.sv
package hpa_pkg;

  typedef enum logic [1:0] {
    HPA_OP_NONE = 2'b00,
    HPA_OP_HALFWORD_PARALLEL_SUM = 2'b01,
    HPA_OP_HALFWORD_PARALLEL_DIFFERENCE = 2'b10,
    HPA_OP_AVERAGE = 2'b11
  } hpa_op_t;

  typedef enum logic [1:0] {
    HPA_SAT_UNSIGNED_CLAMP_OPTION = 2'b00,
    HPA_SAT_SIGNED = 2'b01,
    HPA_SAT_SPARE = 2'b10,
    HPA_SAT_MODULAR = 2'b11
  } hpa_sat_t;

endpackage

// File: rtl/hpa_unit.sv
`timescale 1ns/10ps
`include "hpa_defs.svh"


module hpa_lane #(
  parameter int W = 16
) (
  input wire logic [W-1:0] a_in,
  input wire logic [W-1:0] b_in,
  input wire hpa_pkg::hpa_op_t op_in,
  input wire hpa_pkg::hpa_sat_t sat_in,
  output logic [W-1:0] res_out
);
  logic [W+1:0] a_s;
  logic [W+1:0] a_u;
  logic [W+1:0] b_t;
  logic [W+1:0] cin;
  logic [W+1:0] wide_s;
  logic [W+1:0] wide_u;
  logic [W:0] avg_sum;

  always_comb
  begin
    a_s = {{2{a_in[W-1]}}, a_in};
    a_u = {2'b00, a_in};
    b_t = {{2{b_in[W-1]}}, b_in};
    cin = '0;
    if (op_in == hpa_pkg::HPA_OP_HALFWORD_PARALLEL_DIFFERENCE)
    begin
      b_t = ~b_t;
      cin[0] = 1'b1;
    end
    wide_s = a_s + b_t + cin;
    wide_u = a_u + b_t + cin;
    avg_sum = {1'b0, a_in} + {1'b0, b_in};
    res_out = wide_s[W-1:0];
    if (op_in == hpa_pkg::HPA_OP_AVERAGE)
    begin
      res_out = {avg_sum[W], avg_sum[W-1:2], avg_sum[1] | avg_sum[0]};
    end
    else
    begin
      case (sat_in)
        hpa_pkg::HPA_SAT_SIGNED:
        begin
          if (!wide_s[W+1] && (wide_s[W] || wide_s[W-1]))
          begin
            res_out = `HPA_SMAX;
          end
          else if (wide_s[W+1] && !(wide_s[W] && wide_s[W-1]))
          begin
            res_out = `HPA_SMIN;
          end
        end
        hpa_pkg::HPA_SAT_UNSIGNED_CLAMP_OPTION:
        begin
          if (!wide_u[W+1] && wide_u[W])
          begin
            res_out = `HPA_UMAX;
          end
          else if (wide_u[W+1])
          begin
            res_out = `HPA_UMIN;
          end
          else
          begin
            res_out = wide_u[W-1:0];
          end
        end
        default:
        begin
          res_out = wide_s[W-1:0];
        end
      endcase
    end
  end
endmodule

module hpa_halfword_parallel_arith (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic issue_in,
  input wire logic [31:0] instr_in,
  input wire logic [31:0] src1_in,
  input wire logic [31:0] src2_in,
  output logic [4:0] src1_idx_out,
  output logic [4:0] src2_idx_out,
  output logic wr_en_out,
  output logic [4:0] wr_idx_out,
  output logic [31:0] result_out
);
  hpa_pkg::hpa_op_t op;
  hpa_pkg::hpa_sat_t sat;
  logic fixed_ok;
  logic [31:0] next_result;

  assign src1_idx_out = instr_in[`HPA_SRC1_MSB:`HPA_SRC1_LSB];
  assign src2_idx_out = instr_in[`HPA_SRC2_MSB:`HPA_SRC2_LSB];

  always_comb
  begin
    fixed_ok = instr_in[`HPA_OPC_MSB:`HPA_OPC_LSB] == `HPA_MAJOR_OPC
      && instr_in[`HPA_ZERO3_MSB:`HPA_ZERO3_LSB] == 3'h0
      && !instr_in[`HPA_ZERO1_BIT] && !instr_in[`HPA_TAIL_BIT];
    sat = hpa_pkg::hpa_sat_t'(instr_in[`HPA_SAT_MSB:`HPA_SAT_LSB]);
    op = hpa_pkg::HPA_OP_NONE;
    if (fixed_ok && instr_in[`HPA_SUB_MSB:`HPA_SUB_LSB] == `HPA_SUB_SUM)
    begin
      op = hpa_pkg::HPA_OP_HALFWORD_PARALLEL_SUM;
    end
    else if (fixed_ok && instr_in[`HPA_SUB_MSB:`HPA_SUB_LSB] == `HPA_SUB_DIFF)
    begin
      op = hpa_pkg::HPA_OP_HALFWORD_PARALLEL_DIFFERENCE;
    end
    else if (fixed_ok && instr_in[`HPA_SUB_MSB:`HPA_SUB6_LSB] == `HPA_SUB_AVG)
    begin
      op = hpa_pkg::HPA_OP_AVERAGE;
    end
  end

  hpa_lane #(.W(16)) u_lane_left (
    .a_in(src1_in[31:16]),
    .b_in(src2_in[31:16]),
    .op_in(op),
    .sat_in(sat),
    .res_out(next_result[31:16])
  );

  hpa_lane #(.W(16)) u_lane_right (
    .a_in(src1_in[15:0]),
    .b_in(src2_in[15:0]),
    .op_in(op),
    .sat_in(sat),
    .res_out(next_result[15:0])
  );

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      wr_en_out <= 1'b0;
      wr_idx_out <= `HPA_TGT_RST;
      result_out <= `HPA_RESULT_RST;
    end
    else
    begin
      wr_en_out <= issue_in && op != hpa_pkg::HPA_OP_NONE;
      if (issue_in && op != hpa_pkg::HPA_OP_NONE)
      begin
        wr_idx_out <= instr_in[`HPA_TGT_MSB:`HPA_TGT_LSB];
        result_out <= next_result;
      end
    end
  end

  // Checking helpers
  logic [31:0] chk_a;
  logic [31:0] chk_b;
  logic [4:0] chk_t;
  hpa_pkg::hpa_op_t chk_op;
  hpa_pkg::hpa_sat_t chk_sat;
  logic [15:0] wrap_hi;
  logic [16:0] usum_hi;
  logic [16:0] avg_lo;

  always_ff @(posedge clk_in)
  begin
    chk_a <= src1_in;
    chk_b <= src2_in;
    chk_t <= instr_in[`HPA_TGT_MSB:`HPA_TGT_LSB];
    chk_op <= op;
    chk_sat <= sat;
  end

  assign wrap_hi = chk_a[31:16] + chk_b[31:16];
  assign usum_hi = {1'b0, chk_a[31:16]} + {1'b0, chk_b[31:16]};
  assign avg_lo = {1'b0, chk_a[15:0]} + {1'b0, chk_b[15:0]};

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  sequence sum_seq;
    wr_en_out && chk_op == hpa_pkg::HPA_OP_HALFWORD_PARALLEL_SUM;
  endsequence

  sequence diff_seq;
    wr_en_out && chk_op == hpa_pkg::HPA_OP_HALFWORD_PARALLEL_DIFFERENCE;
  endsequence

  sequence bad_issue_seq;
    issue_in && op == hpa_pkg::HPA_OP_NONE;
  endsequence

  decode_reject_a: assert property (bad_issue_seq |=> !wr_en_out)
    else $error("unrecognised instruction wrote a result");
  target_pair_a: assert property (issue_in && op != hpa_pkg::HPA_OP_NONE |=> wr_en_out && wr_idx_out == chk_t)
    else $error("result not written to target");
  wrap_sum_a: assert property (sum_seq and chk_sat == hpa_pkg::HPA_SAT_MODULAR |->
      result_out == {wrap_hi, chk_a[15:0] + chk_b[15:0]})
    else $error("modular lane sum wrong");
  wrap_diff_a: assert property (diff_seq and chk_sat == hpa_pkg::HPA_SAT_MODULAR |->
      result_out == {chk_a[31:16] - chk_b[31:16], chk_a[15:0] - chk_b[15:0]})
    else $error("modular lane difference wrong");
  signed_high_a: assert property (sum_seq and chk_sat == hpa_pkg::HPA_SAT_SIGNED
      && !chk_a[31] && !chk_b[31] && wrap_hi[15] |-> result_out[31:16] == `HPA_SMAX)
    else $error("signed overflow not clamped high");
  signed_low_a: assert property (sum_seq and chk_sat == hpa_pkg::HPA_SAT_SIGNED
      && chk_a[31] && chk_b[31] && !wrap_hi[15] |-> result_out[31:16] == `HPA_SMIN)
    else $error("signed underflow not clamped low");
  clamp_max_a: assert property (sum_seq and chk_sat == hpa_pkg::HPA_SAT_UNSIGNED_CLAMP_OPTION
      && !chk_b[31] && usum_hi[16] |-> result_out[31:16] == `HPA_UMAX)
    else $error("unsigned overflow not clamped");
  clamp_min_a: assert property (diff_seq and chk_sat == hpa_pkg::HPA_SAT_UNSIGNED_CLAMP_OPTION
      && !chk_b[15] && chk_a[15:0] < chk_b[15:0] |-> result_out[15:0] == `HPA_UMIN)
    else $error("unsigned underflow not clamped");
  avg_round_a: assert property (wr_en_out && chk_op == hpa_pkg::HPA_OP_AVERAGE |->
      result_out[15] == avg_lo[16] && result_out[0] == (avg_lo[1] | avg_lo[0]))
    else $error("average carry or rounding bit wrong");
endmodule
